// File: core/svw_deframer.sv
// serial video word deframer with its configuration and status register bank
// Notes on behaviour
// - word holds data, hsync and vsync bits
// - data bits programmable from 8 to 16
// - length is width plus encode plus parity
// - no parity: encode, hsync, vsync, then data
// - lengths 18/16/14/12 map widths 16/14/12/10
// - parity: two parity bits lead the word
// - first configuration register resets to 0xb5
// - error counts clear on read by default
// - start timeout defaults divide 1024, count one
// - end timeout defaults divide 1024, count one
// - edge control register resets to 0x20
// - own control address resets to 0xf8
// - end of frame marker resets all ones
// - peripheral interface register resets to zero
// - sixteen bit parity threshold, reset sixteen
// - sixteen bit parity error count, read only
// - prbs error count, read only, reset zero
// - five read only link error flags
// - bits arrive least significant position first
// - width select codes, top bit means 18
`timescale 1ns/1ps
`include "svw_regs.svh"
module svw_deframer
  import svw_pkg::*;
#(
  parameter int MAX_SERIAL = `SVW_MAX_SERIAL
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire svw_wb_req_t wb_req_i,
  input wire logic [5:2] wb_adr_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bit_valid_i,
  input wire logic bit_i,
  input wire logic word_sync_i,
  input wire logic prbs_err_i,
  input wire logic [4:0] link_err_i,
  input wire logic [1:0] timer_arm_i,
  input wire logic activity_i,
  output svw_word_t word_o,
  output logic word_valid_o,
  output logic parity_err_o,
  output logic hsync_act_o,
  output logic vsync_act_o,
  output logic parity_alarm_o,
  output logic [1:0] timeout_o,
  output logic [7:0] own_addr_o,
  output logic [7:0] end_mark_o,
  output logic [7:0] periph_cfg_o,
  output logic [7:0] spread_cfg_o
);
  // elaboration check: the shift register must hold the longest word
  if (MAX_SERIAL < `SVW_MAX_SERIAL) begin : g_bad_max_serial
    $error("MAX_SERIAL must hold the longest word of 22 bits");
  end

  // ==========================================================
  // register bank
  logic [7:0] rate_q, spread_q, sto_q, eto_q, edge_q, addr_q, mark_q, periph_q, pthr_lo_q, pthr_hi_q;
  logic [15:0] perr_q;
  logic [7:0] prbs_q;
  logic [4:0] flags_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic req, wr, rd, wr_lane;
  assign req = wb_req_i.cyc && wb_req_i.stb && !ack_q;
  assign wr = req && wb_req_i.we;
  assign rd = req && !wb_req_i.we;
  assign wr_lane = wr && wb_req_i.sel[0];

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rate_q <= `SVW_RST_RATE_WIDTH;
      spread_q <= `SVW_RST_SPREAD_ERR;
      sto_q <= `SVW_RST_START_TO;
      eto_q <= `SVW_RST_END_TO;
      edge_q <= `SVW_RST_EDGE_TEST;
      addr_q <= `SVW_RST_OWN_ADDR;
      mark_q <= `SVW_RST_END_MARK;
      periph_q <= `SVW_RST_PERIPH;
      pthr_lo_q <= `SVW_RST_PTHR_LO;
      pthr_hi_q <= `SVW_RST_PTHR_HI;
    end else if (wr_lane) begin
      if (wb_adr_i == `SVW_IDX_RATE_WIDTH) begin
        rate_q <= wb_req_i.dat[7:0];
      end else if (wb_adr_i == `SVW_IDX_SPREAD_ERR) begin
        spread_q <= wb_req_i.dat[7:0] & `SVW_MASK_SPREAD_ERR;
      end else if (wb_adr_i == `SVW_IDX_START_TO) begin
        sto_q <= wb_req_i.dat[7:0];
      end else if (wb_adr_i == `SVW_IDX_END_TO) begin
        eto_q <= wb_req_i.dat[7:0];
      end else if (wb_adr_i == `SVW_IDX_EDGE_TEST) begin
        edge_q <= wb_req_i.dat[7:0] & `SVW_MASK_EDGE_TEST;
      end else if (wb_adr_i == `SVW_IDX_OWN_ADDR) begin
        addr_q <= wb_req_i.dat[7:0];
      end else if (wb_adr_i == `SVW_IDX_END_MARK) begin
        mark_q <= wb_req_i.dat[7:0];
      end else if (wb_adr_i == `SVW_IDX_PERIPH) begin
        periph_q <= wb_req_i.dat[7:0];
      end else if (wb_adr_i == `SVW_IDX_PTHR_LO) begin
        pthr_lo_q <= wb_req_i.dat[7:0];
      end else if (wb_adr_i == `SVW_IDX_PTHR_HI) begin
        pthr_hi_q <= wb_req_i.dat[7:0];
      end
    end
  end

  // read mux, answers one cycle after the strobe; unmapped reads give zero
  logic [7:0] rmux;
  always_comb begin
    if (wb_adr_i == `SVW_IDX_RATE_WIDTH) begin
      rmux = rate_q;
    end else if (wb_adr_i == `SVW_IDX_SPREAD_ERR) begin
      rmux = spread_q;
    end else if (wb_adr_i == `SVW_IDX_START_TO) begin
      rmux = sto_q;
    end else if (wb_adr_i == `SVW_IDX_END_TO) begin
      rmux = eto_q;
    end else if (wb_adr_i == `SVW_IDX_EDGE_TEST) begin
      rmux = edge_q;
    end else if (wb_adr_i == `SVW_IDX_OWN_ADDR) begin
      rmux = addr_q;
    end else if (wb_adr_i == `SVW_IDX_END_MARK) begin
      rmux = mark_q;
    end else if (wb_adr_i == `SVW_IDX_PERIPH) begin
      rmux = periph_q;
    end else if (wb_adr_i == `SVW_IDX_PTHR_LO) begin
      rmux = pthr_lo_q;
    end else if (wb_adr_i == `SVW_IDX_PTHR_HI) begin
      rmux = pthr_hi_q;
    end else if (wb_adr_i == `SVW_IDX_PERR_LO) begin
      rmux = perr_q[7:0];
    end else if (wb_adr_i == `SVW_IDX_PERR_HI) begin
      rmux = perr_q[15:8];
    end else if (wb_adr_i == `SVW_IDX_PRBS_ERR) begin
      rmux = prbs_q;
    end else if (wb_adr_i == `SVW_IDX_FLAGS) begin
      rmux = {3'h0, flags_q};
    end else begin
      rmux = 8'h00;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      rdat_q <= rd ? {24'h00_0000, rmux} : 32'h0000_0000;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ==========================================================
  // word assembly
  logic par_en;
  logic [4:0] parallel_width_sel, slen;
  assign par_en = rate_q[`SVW_POS_PAR_EN];
  always_comb begin
    if (rate_q[2]) begin
      parallel_width_sel = 5'd18;
    end else begin
      parallel_width_sel = 5'd10 + {2'b00, rate_q[1:0], 1'b0};
    end
    slen = parallel_width_sel + 5'(`SVW_ENC_BITS) + (par_en ? 5'(`SVW_PAR_BITS) : 5'd0);
  end

  logic [MAX_SERIAL-1:0] sh_q;
  logic [4:0] cnt_q;
  logic done;
  assign done = bit_valid_i && !word_sync_i && (cnt_q == slen - 5'd1);
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cnt_q <= 5'd0;
      sh_q <= '0;
    end else if (word_sync_i) begin
      cnt_q <= 5'd0;
    end else if (bit_valid_i) begin
      sh_q[cnt_q] <= bit_i;
      cnt_q <= done ? 5'd0 : cnt_q + 5'd1;
    end
  end

  // full word including the bit arriving now
  logic [MAX_SERIAL-1:0] full;
  logic [MAX_SERIAL-1:0] body;
  logic [15:0] dmask;
  logic pa, pb;
  always_comb begin
    full = sh_q;
    full[cnt_q] = bit_i;
    body = par_en ? (full >> `SVW_PAR_BITS) : full;
    dmask = 16'hffff >> (5'd18 - parallel_width_sel);
    pa = ^(body & ((MAX_SERIAL)'(1) << parallel_width_sel + 5'd2) - (MAX_SERIAL)'(1));
    pb = ~pa;
  end

  logic perr_ev;
  assign perr_ev = done && par_en && ((full[0] != pa) || (full[1] != pb));

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      word_o <= '0;
      word_valid_o <= 1'b0;
      parity_err_o <= 1'b0;
      hsync_act_o <= 1'b0;
      vsync_act_o <= 1'b0;
    end else begin
      word_valid_o <= done;
      parity_err_o <= perr_ev;
      if (done) begin
        word_o.enc <= body[1:0];
        word_o.hsync <= body[2];
        word_o.vsync <= body[3];
        word_o.data <= body[19:4] & dmask;
        hsync_act_o <= body[2] ~^ edge_q[`SVW_POS_HORIZ_SYNC_EDGE_SEL];
        vsync_act_o <= body[3] ~^ edge_q[`SVW_POS_VERT_SYNC_EDGE_SEL];
      end
    end
  end

  // ==========================================================
  // error counters and flags; an event in the clearing cycle is kept
  logic auto_rst, rd_ack, clr_perr, clr_prbs, clr_flags;
  logic [15:0] pthr;
  assign auto_rst = spread_q[`SVW_POS_AUTO_ERR];
  assign pthr = {pthr_hi_q, pthr_lo_q};
  assign rd_ack = rd && !auto_rst;
  assign clr_perr = (rd_ack && wb_adr_i == `SVW_IDX_PERR_HI) || (auto_rst && parity_alarm_o);
  assign clr_prbs = rd_ack && wb_adr_i == `SVW_IDX_PRBS_ERR;
  assign clr_flags = rd && wb_adr_i == `SVW_IDX_FLAGS;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      perr_q <= 16'h0000;
    end else if (clr_perr) begin
      perr_q <= {15'h0000, perr_ev};
    end else if (perr_ev && perr_q != 16'hffff) begin
      perr_q <= perr_q + 16'h0001;
    end
  end

  logic prbs_ev;
  assign prbs_ev = prbs_err_i && edge_q[`SVW_POS_PRBS_EN];
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      prbs_q <= 8'h00;
    end else if (clr_prbs) begin
      prbs_q <= {7'h00, prbs_ev};
    end else if (prbs_ev && prbs_q != 8'hff) begin
      prbs_q <= prbs_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      flags_q <= 5'h00;
    end else begin
      flags_q <= (clr_flags ? 5'h00 : flags_q) | link_err_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      parity_alarm_o <= 1'b0;
    end else begin
      parity_alarm_o <= !clr_perr && (perr_q >= pthr) && (perr_q != 16'h0000);
    end
  end

  // ==========================================================
  // start and end timeouts, ticked once per word
  logic [7:0] to_cfg [2];
  assign to_cfg[0] = sto_q;
  assign to_cfg[1] = eto_q;
  for (genvar k = 0; k < 2; k++) begin : g_to
    logic run_q, exp_q;
    logic [15:0] div_q;
    logic [3:0] n_q;
    logic div_end;
    assign div_end = done && (div_q == (16'h0001 << to_cfg[k][7:4]) - 16'h0001);
    always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
        run_q <= 1'b0;
        exp_q <= 1'b0;
        div_q <= 16'h0000;
        n_q <= 4'h0;
      end else begin
        exp_q <= 1'b0;
        if (timer_arm_i[k] || (run_q && activity_i)) begin
          run_q <= 1'b1;
          div_q <= 16'h0000;
          n_q <= 4'h0;
        end else if (run_q && done) begin
          div_q <= div_end ? 16'h0000 : div_q + 16'h0001;
          if (div_end) begin
            if (n_q == to_cfg[k][3:0]) begin
              run_q <= 1'b0;
              exp_q <= 1'b1;
            end else begin
              n_q <= n_q + 4'h1;
            end
          end
        end
      end
    end
    assign timeout_o[k] = exp_q;
  end

  assign own_addr_o = addr_q;
  assign end_mark_o = mark_q;
  assign periph_cfg_o = periph_q;
  assign spread_cfg_o = spread_q;

  // ==========================================================
  // checks
  chk_ack_one: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle after strobe");
  chk_reset_cfg: assert property (@(posedge clk_sys_i)
    !rst_b_i |=> rate_q == 8'hb5 && edge_q == 8'h20 && addr_q == 8'hf8 && mark_q == 8'hff)
    else $error("configuration reset values wrong");
  chk_thr_reset: assert property (@(posedge clk_sys_i) !rst_b_i |=> pthr == 16'h0010)
    else $error("parity threshold reset not sixteen");
  chk_len_noparity: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !par_en && rate_q[2] |-> slen == 5'd20)
    else $error("word length without parity wrong");
  chk_word_valid: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    done |=> word_valid_o && word_o.hsync == $past(body[2]))
    else $error("word not delivered after last bit");
  chk_perr_count: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    perr_ev && !clr_perr && perr_q < 16'hfffe |=> perr_q == $past(perr_q) + 16'h0001)
    else $error("parity error not counted");
  chk_read_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    rd && !auto_rst && wb_adr_i == `SVW_IDX_PRBS_ERR && !prbs_ev |=> prbs_q == 8'h00)
    else $error("prbs count not cleared by read");
  chk_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    link_err_i[0] |=> flags_q[0] ##1 (flags_q[0] || $past(clr_flags)))
    else $error("link flag lost");
  chk_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (spread_q & ~`SVW_MASK_SPREAD_ERR) == 8'h00 && (edge_q & ~`SVW_MASK_EDGE_TEST) == 8'h00)
    else $error("reserved bits not zero");
  chk_data_width: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    word_valid_o && rate_q[2:0] == 3'b000 |-> word_o.data[15:8] == 8'h00)
    else $error("data wider than selected width");
  chk_auto_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    auto_rst && parity_alarm_o && !perr_ev |=> perr_q == 16'h0000)
    else $error("parity count not emptied by alarm");
  chk_no_parity_err: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    done && !par_en |=> !parity_err_o)
    else $error("parity error without parity");
  chk_layout_plain: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    done && !par_en |=> word_o.enc == $past(full[1:0]) && word_o.hsync == $past(full[2]))
    else $error("plain word layout wrong");
  chk_layout_parity: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    done && par_en |=> word_o.enc == $past(full[3:2]) && word_o.vsync == $past(full[5]))
    else $error("parity word layout wrong");
  chk_ro_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_lane && wb_adr_i == `SVW_IDX_PERR_LO && !perr_ev && !clr_perr |=> perr_q == $past(perr_q))
    else $error("read only count changed by write");
  chk_unmapped_read: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    rd && wb_adr_i > `SVW_IDX_FLAGS |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_to_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    timeout_o != 2'b00 |=> (timeout_o & $past(timeout_o)) == 2'b00)
    else $error("timeout pulse longer than one cycle");
  cov_parity_word: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) done && par_en);
  cov_parity_err: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) perr_ev);
  cov_timeout: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) timeout_o[0]);
  cov_alarm: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) parity_alarm_o);
  cov_auto_clear: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) auto_rst && clr_perr);
endmodule

// File: core/svw_pkg.sv
// types shared by the serial video word deframer
package svw_pkg;
  typedef struct packed {
    logic [15:0] data;
    logic vsync;
    logic hsync;
    logic [1:0] enc;
  } svw_word_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } svw_wb_req_t;
endpackage

// File: core/svw_regs.svh
// register offsets, field positions, reset values and masks of the serial video word deframer
`ifndef SVW_REGS_SVH
`define SVW_REGS_SVH
// register indices; byte address is index times four
`define SVW_IDX_RATE_WIDTH 4'h0
`define SVW_IDX_SPREAD_ERR 4'h1
`define SVW_IDX_START_TO 4'h2
`define SVW_IDX_END_TO 4'h3
`define SVW_IDX_EDGE_TEST 4'h4
`define SVW_IDX_OWN_ADDR 4'h5
`define SVW_IDX_END_MARK 4'h6
`define SVW_IDX_PERIPH 4'h7
`define SVW_IDX_PTHR_LO 4'h8
`define SVW_IDX_PTHR_HI 4'h9
`define SVW_IDX_PERR_LO 4'ha
`define SVW_IDX_PERR_HI 4'hb
`define SVW_IDX_PRBS_ERR 4'hc
`define SVW_IDX_FLAGS 4'hd
// reset values
`define SVW_RST_RATE_WIDTH 8'hb5
`define SVW_RST_SPREAD_ERR 8'h00
`define SVW_RST_START_TO 8'ha0
`define SVW_RST_END_TO 8'ha0
`define SVW_RST_EDGE_TEST 8'h20
`define SVW_RST_OWN_ADDR 8'hf8
`define SVW_RST_END_MARK 8'hff
`define SVW_RST_PERIPH 8'h00
`define SVW_RST_PTHR_LO 8'h10
`define SVW_RST_PTHR_HI 8'h00
// writable bit masks, plus the bits of the read only flags; reserved bits read zero
`define SVW_MASK_SPREAD_ERR 8'hf8
`define SVW_MASK_EDGE_TEST 8'he9
`define SVW_MASK_FLAGS 8'h1f
// field positions
`define SVW_POS_PAR_EN 3
`define SVW_POS_AUTO_ERR 5
`define SVW_POS_VERT_SYNC_EDGE_SEL 7
`define SVW_POS_HORIZ_SYNC_EDGE_SEL 6
`define SVW_POS_PRBS_EN 0
// word layout
`define SVW_MAX_SERIAL 22
`define SVW_ENC_BITS 2
`define SVW_PAR_BITS 2
`endif

// File: tb/svw_ser_model.sv
// serializer partner model that drives serial video words into the deframer
`timescale 1ns/1ps
module svw_ser_model (
  input wire logic clk_sys_i,
  output logic bit_valid_o,
  output logic bit_o,
  output logic word_sync_o
);
  initial begin
    bit_valid_o = 1'b0;
    bit_o = 1'b0;
    word_sync_o = 1'b0;
  end
  // ==========================================================
  // word transmission, one bit per strobe
  task automatic send(input logic [15:0] d, input logic hs, input logic vs, input logic [1:0] enc,
                      input logic [2:0] wc, input logic par, input logic bad);
    logic [21:0] w;
    logic pa;
    int n;
    n = wc[2] ? 20 : 12 + 2 * int'(wc[1:0]);
    w = {2'b00, d, vs, hs, enc};
    w = w & ((22'h1 << n) - 22'h1);
    if (par) begin
      pa = (^w) ^ bad;
      w = {w[19:0], ~pa, pa};
      n = n + 2;
    end
    @(posedge clk_sys_i);
    word_sync_o <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_i);
      word_sync_o <= 1'b0;
      bit_valid_o <= 1'b1;
      bit_o <= w[i];
    end
    @(posedge clk_sys_i);
    bit_valid_o <= 1'b0;
    // released line shows the inverse of the last bit
    bit_o <= ~w[n-1];
  endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for the serial video word deframer
`timescale 1ns/1ps
module testbench;
  import svw_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  svw_wb_req_t wb_req = '0;
  logic [5:2] wb_adr = 4'h0;
  logic prbs_err = 1'b0;
  logic [4:0] link_err = 5'h00;
  logic [1:0] timer_arm = 2'h0;
  logic activity = 1'b0;
  logic bit_valid, bit_s, word_sync, wb_ack, word_valid, parity_err, hsync_act, vsync_act, parity_alarm;
  logic [31:0] wb_dat;
  logic [31:0] rd;
  svw_word_t word;
  logic [1:0] timeout;
  logic [7:0] own_addr, end_mark, periph_cfg, spread_cfg;
  int n_mismatch = 0;
  int checked = 0;
  int wv_cnt = 0;
  int to_at [2] = '{0, 0};
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  logic [7:0] rst_tab [14] = '{8'hb5, 8'h00, 8'ha0, 8'ha0, 8'h20, 8'hf8, 8'hff,
                               8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  always #5 clk_sys_i = ~clk_sys_i;
  svw_deframer u_svw_deframer (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .wb_req_i(wb_req), .wb_adr_i(wb_adr),
    .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .bit_valid_i(bit_valid), .bit_i(bit_s), .word_sync_i(word_sync),
    .prbs_err_i(prbs_err), .link_err_i(link_err), .timer_arm_i(timer_arm), .activity_i(activity),
    .word_o(word), .word_valid_o(word_valid), .parity_err_o(parity_err), .hsync_act_o(hsync_act),
    .vsync_act_o(vsync_act), .parity_alarm_o(parity_alarm), .timeout_o(timeout), .own_addr_o(own_addr),
    .end_mark_o(end_mark), .periph_cfg_o(periph_cfg), .spread_cfg_o(spread_cfg));
  svw_ser_model u_svw_ser_model (.clk_sys_i(clk_sys_i), .bit_valid_o(bit_valid), .bit_o(bit_s),
    .word_sync_o(word_sync));
  // ==========================================================
  // word and timeout monitor
  always @(posedge clk_sys_i) begin
    if (word_valid === 1'b1) wv_cnt++;
    for (int k = 0; k < 2; k++) if (timeout[k] === 1'b1 && to_at[k] == 0) to_at[k] = wv_cnt;
  end
  // ==========================================================
  // shared tasks
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb_cycle(input logic we, input logic [3:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk_sys_i);
    wb_req.cyc <= 1'b1;
    wb_req.stb <= 1'b1;
    wb_req.we <= we;
    wb_req.sel <= 4'hf;
    wb_req.dat <= {24'h000000, wd};
    wb_adr <= idx;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (wb_ack !== 1'b1) begin
      $display("[FAIL] t=%0t got %h expected %h", $time, wb_ack, 1'b1);
      n_mismatch++;
      wrap_up();
    end
    rd = wb_dat;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    wb_req.we <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
    wb_cycle(1'b0, idx, 8'h00);
    check(rd, {24'h000000, exp});
  endtask
  task automatic word_chk(input logic [15:0] d, input logic hs, input logic vs, input logic [1:0] enc,
                          input logic [2:0] wc, input logic par, input logic bad);
    logic [15:0] m;
    m = 16'hffff >> (wc[2] ? 0 : 8 - 2 * int'(wc[1:0]));
    u_svw_ser_model.send(d, hs, vs, enc, wc, par, bad);
    #1;
    check(word_valid, 32'h1);
    check(word.data, d & m);
    check({word.vsync, word.hsync, word.enc}, {vs, hs, enc});
    check(parity_err, par & bad);
    @(posedge clk_sys_i);
    #1;
    check({hsync_act, vsync_act}, {~hs, ~vs});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      rd_chk(i[3:0], rst_tab[i]);
    end
    check({own_addr, end_mark, periph_cfg, spread_cfg}, 32'hf8ff0000);
    wb_cycle(1'b1, 4'h1, 8'hff);
    rd_chk(4'h1, 8'hf8);
    wb_cycle(1'b1, 4'h4, 8'hff);
    rd_chk(4'h4, 8'he9);
    wb_cycle(1'b1, 4'ha, 8'hff);
    rd_chk(4'ha, 8'h00);
    wb_cycle(1'b1, 4'he, 8'hff);
    rd_chk(4'he, 8'h00);
    wb_cycle(1'b1, 4'h1, 8'h00);
    wb_cycle(1'b1, 4'h4, 8'h21);
    wb_cycle(1'b1, 4'h5, 8'h3c);
    rd_chk(4'h5, 8'h3c);
    check(own_addr, 32'h3c);
    for (int p = 0; p < 2; p++) begin
      for (int j = 0; j < 6; j++) begin
        wb_cycle(1'b1, 4'h0, {4'hb, p[0], codes[j]});
        word_chk(16'h9e37, codes[j][0], ~p[0], 2'h2, codes[j], p[0], 1'b0);
      end
    end
    // two corrupted words against a threshold of two
    wb_cycle(1'b1, 4'h0, 8'hbb);
    wb_cycle(1'b1, 4'h8, 8'h02);
    repeat (2) word_chk(16'h5a5a, 1'b1, 1'b0, 2'h1, 3'h3, 1'b1, 1'b1);
    check(parity_alarm, 32'h1);
    rd_chk(4'ha, 8'h02);
    rd_chk(4'hb, 8'h00);
    rd_chk(4'ha, 8'h00);
    check(parity_alarm, 32'h0);
    repeat (3) begin
      @(posedge clk_sys_i) prbs_err <= 1'b1;
      @(posedge clk_sys_i) prbs_err <= 1'b0;
    end
    @(posedge clk_sys_i) link_err <= 5'h15;
    @(posedge clk_sys_i) link_err <= 5'h00;
    rd_chk(4'hc, 8'h03);
    rd_chk(4'hc, 8'h00);
    rd_chk(4'hd, 8'h15);
    rd_chk(4'hd, 8'h00);
    // automatic clearing: reads keep the counts, a raised alarm empties the parity count
    wb_cycle(1'b1, 4'h1, 8'h20);
    repeat (2) word_chk(16'h1234, 1'b0, 1'b1, 2'h2, 3'h3, 1'b1, 1'b1);
    check(parity_alarm, 32'h1);
    @(posedge clk_sys_i);
    #1;
    check(parity_alarm, 32'h0);
    rd_chk(4'ha, 8'h00);
    repeat (2) begin
      @(posedge clk_sys_i) prbs_err <= 1'b1;
      @(posedge clk_sys_i) prbs_err <= 1'b0;
    end
    rd_chk(4'hc, 8'h02);
    rd_chk(4'hc, 8'h02);
    wb_cycle(1'b1, 4'h1, 8'h00);
    rd_chk(4'hc, 8'h02);
    rd_chk(4'hc, 8'h00);
    // both timers at their default divide and count
    wb_cycle(1'b1, 4'h0, 8'hb0);
    @(posedge clk_sys_i) timer_arm <= 2'h3;
    wv_cnt = 0;
    @(posedge clk_sys_i) timer_arm <= 2'h0;
    repeat (1030) u_svw_ser_model.send(16'h0000, 1'b0, 1'b0, 2'h1, 3'h0, 1'b0, 1'b0);
    check(to_at[0], 32'd1024);
    check(to_at[1], 32'd1024);
    wrap_up();
  end
  initial begin
    #1000000;
    $display("[FAIL] t=%0t got %h expected %h", $time, 1'b0, 1'b1);
    n_mismatch++;
    wrap_up();
  end
endmodule
